/* File: hdl/wdt_top.sv */
// Watchdog timeout unit with its AXI4-Lite register slave.
// Notes on behaviour
// - 6-bit counter fed by 12-bit prescaler.
// - Unserviced overflow requests a system reset.
// - Select 1 short period, 0 long; reset clears.
// - Any service write clears counter, upper prescaler.
// - Service address reads vector byte, no servicing.
// - Overflow drives reset pin 32 ticks, flags cause.
// - Prescaler cleared 4096 ticks after power-up.
// - Internal reset clears prescaler and counter.
// - Reset vector fetch clears the prescaler.
// - Disable bit set means never a watchdog reset; an illegal stop still resets.
// - Timeout raises the CPU interrupt when its cause bit is unmasked.
// - Monitor mode with test voltage disables.
// - Counting continues during wait mode.
// - Stop gates oscillator ticks, clears prescaler.
// - Stop disabled makes stop an illegal reset.
// - Break with test voltage on reset disables.
`timescale 1ns/1ns
`default_nettype none
module wdt_top
	import wdt_pkg::*;
#(
	parameter int RST_PULSE = `WDT_RST_PULSE,
	parameter int POR_CYCLES = `WDT_POR_CYCLES,
	parameter logic [7:0] VEC_LO = `WDT_VEC_LO
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`WDT_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`WDT_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic internal_osc_clock_tick,
	input wire logic internal_reset,
	input wire logic vector_fetch,
	input wire logic monitor_mode,
	input wire logic test_high_voltage_irq,
	input wire logic test_high_voltage_rst,
	input wire logic break_active,
	input wire logic stop_exec,
	input wire logic stop_wake,
	output logic stop_mode,
	output logic wdog_reset_req,
	output logic illegal_op_reset,
	output logic rst_pin_out,
	output logic rst_pin_oe,
	output logic irq
);
	wdt_state_t s_r;
	wdt_state_t s_nxt;

	logic [`WDT_PRE_W-1:0] pre_cnt;
	logic osc_run;
	logic wd_off;
	logic roll;
	logic wd_ovf;
	logic commit;
	logic service;
	logic por_clr;
	logic stop_enter;
	logic pre_clr_all;
	logic [`WDT_PRE_W-1:0] stage_mask;
	logic [`WDT_IDX_W-1:0] ar_idx;

	if (POR_CYCLES < 1 || POR_CYCLES >= (1 << `WDT_POR_W)
		|| RST_PULSE < 1) begin : g_chk
		$error("wdt_top: power-up or pulse count out of range");
	end

	// Oscillator ticks pass only outside stop; wait mode does not gate.
	assign osc_run = internal_osc_clock_tick && (s_r.pwr == WDT_RUN);
	assign wd_off = s_r.cfg[`WDT_CFG_DIS]
		|| (monitor_mode
		&& (test_high_voltage_irq || test_high_voltage_rst))
		|| (break_active && test_high_voltage_rst);
	// The selected stage decides the period.
	assign stage_mask = s_r.cfg[`WDT_CFG_TSEL]
		? `WDT_PRE_W'((2 << `WDT_SHORT_STAGE) - 1)
		: `WDT_PRE_W'((2 << `WDT_LONG_STAGE) - 1);
	assign roll = osc_run && (&(pre_cnt | ~stage_mask));
	// Overflow after the last rollover of the 6-bit counter.
	assign wd_ovf = roll && (&s_r.wd_cnt) && !wd_off && s_r.por_done
		&& !internal_reset;
	assign commit = s_r.aw_have && s_r.w_have && !s_r.bvalid;
	assign service = commit && (s_r.aw_idx == `WDT_IDX_SERVICE);
	assign por_clr = !s_r.por_done && internal_osc_clock_tick
		&& (s_r.por_cnt == `WDT_POR_W'(POR_CYCLES - 1));
	assign stop_enter = stop_exec && (s_r.pwr == WDT_RUN)
		&& !s_r.cfg[`WDT_CFG_STOPDIS];
	assign pre_clr_all = por_clr || internal_reset
		|| vector_fetch
		|| stop_enter;
	assign ar_idx = s_axi_araddr[`WDT_ADDR_W-1:2];

	wdt_prescaler #(
		.W(`WDT_PRE_W),
		.KEEP_LO(`WDT_SVC_KEEP_LO)
	) u_pre (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(osc_run),
		.clr_all(pre_clr_all),
		.clr_hi(service),
		.count(pre_cnt)
	);

	wdt_pulse_stretch #(
		.LEN(RST_PULSE)
	) u_rst (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(wd_ovf),
		.tick(internal_osc_clock_tick),
		.active(rst_pin_oe)
	);

	always_comb begin
		s_nxt = s_r;
		s_nxt.wdog_req = wd_ovf;
		s_nxt.ilop_req = stop_exec && (s_r.pwr == WDT_RUN)
			&& s_r.cfg[`WDT_CFG_STOPDIS];
		if (!s_r.por_done && internal_osc_clock_tick) begin
			s_nxt.por_cnt = s_r.por_cnt + `WDT_POR_W'(1);
			s_nxt.por_done = por_clr;
		end
		// Counter is held at zero while disabled so it restarts fresh.
		if (internal_reset || service || wd_off) begin
			s_nxt.wd_cnt = '0;
		end else if (roll && s_r.por_done) begin
			s_nxt.wd_cnt = s_r.wd_cnt + `WDT_CNT_W'(1);
		end
		case (s_r.pwr)
			WDT_RUN: begin
				if (stop_enter) begin
					s_nxt.pwr = WDT_STOP;
				end
			end
			WDT_STOP: begin
				if (stop_wake) begin
					s_nxt.pwr = WDT_RUN;
				end
			end
			default: begin
				s_nxt.pwr = WDT_RUN;
			end
		endcase
		if (s_axi_awvalid && s_axi_awready) begin
			s_nxt.aw_have = 1'b1;
			s_nxt.aw_idx = s_axi_awaddr[`WDT_ADDR_W-1:2];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_nxt.w_have = 1'b1;
			s_nxt.w_data = s_axi_wdata[7:0];
			s_nxt.w_strb0 = s_axi_wstrb[0];
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (commit) begin
			s_nxt.aw_have = 1'b0;
			s_nxt.w_have = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = `WDT_RESP_OKAY;
			if (s_r.aw_idx == `WDT_IDX_SERVICE) begin
				s_nxt.bresp = `WDT_RESP_OKAY;
			end else if (s_r.aw_idx == `WDT_IDX_CONFIG) begin
				if (s_r.w_strb0) begin
					s_nxt.cfg = s_r.w_data[`WDT_CFG_W-1:0];
				end
			end else if (s_r.aw_idx == `WDT_IDX_MASK) begin
				if (s_r.w_strb0) begin
					s_nxt.mask = s_r.w_data[`WDT_CAUSE_W-1:0];
				end
			end else if (s_r.aw_idx == `WDT_IDX_CAUSE) begin
				if (s_r.w_strb0) begin
					s_nxt.cause = s_r.cause
						& ~s_r.w_data[`WDT_CAUSE_W-1:0];
				end
			end else begin
				s_nxt.bresp = `WDT_RESP_SLVERR;
			end
		end
		// A new cause wins over a clear arriving in the same cycle.
		s_nxt.cause[`WDT_CAUSE_WDOG] = s_nxt.cause[`WDT_CAUSE_WDOG]
			|| wd_ovf;
		s_nxt.cause[`WDT_CAUSE_ILOP] = s_nxt.cause[`WDT_CAUSE_ILOP]
			|| s_nxt.ilop_req;
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = `WDT_RESP_OKAY;
			s_nxt.rdata = '0;
			if (ar_idx == `WDT_IDX_SERVICE) begin
				s_nxt.rdata = {24'h000000, VEC_LO};
			end else if (ar_idx == `WDT_IDX_CONFIG) begin
				s_nxt.rdata = 32'(s_r.cfg);
			end else if (ar_idx == `WDT_IDX_CAUSE) begin
				s_nxt.rdata = 32'(s_r.cause);
			end else if (ar_idx == `WDT_IDX_MASK) begin
				s_nxt.rdata = 32'(s_r.mask);
			end else begin
				s_nxt.rresp = `WDT_RESP_SLVERR;
			end
		end
	end

	// Cause and configuration survive the internal reset on purpose, so
	// software can tell after the restart why the system went down.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
			s_r.pwr <= WDT_RUN;
			s_r.cfg <= `WDT_CFG_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign s_axi_awready = !s_r.aw_have && !s_r.bvalid;
	assign s_axi_wready = !s_r.w_have && !s_r.bvalid;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = !s_r.rvalid;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rdata = s_r.rdata;
	assign s_axi_rresp = s_r.rresp;
	assign stop_mode = (s_r.pwr == WDT_STOP);
	assign wdog_reset_req = s_r.wdog_req;
	assign illegal_op_reset = s_r.ilop_req;
	assign rst_pin_out = 1'b0;
	// The line reports reset causes only; a timeout itself is a reset.
	assign irq = |(s_r.cause & s_r.mask);

	// Counts oscillator ticks while the reset pin is driven low.
	logic [7:0] pin_ticks;
	always_ff @(posedge aclk) begin
		if (!aresetn || !rst_pin_oe) begin
			pin_ticks <= 8'h00;
		end else if (internal_osc_clock_tick) begin
			pin_ticks <= pin_ticks + 8'h01;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_SVC_CLEARS: assert property (
		service && !roll |=> s_r.wd_cnt == '0)
		else $error("service write did not clear the counter");
	AST_READ_VECTOR: assert property (
		s_axi_arvalid && s_axi_arready && ar_idx == `WDT_IDX_SERVICE
		|=> s_axi_rvalid && s_axi_rdata == {24'h000000, VEC_LO})
		else $error("service read returned the wrong byte");
	AST_FETCH_CLR: assert property (
		vector_fetch |=> pre_cnt == '0)
		else $error("vector fetch left the prescaler running");
	AST_POR_CLR: assert property (
		por_clr |=> pre_cnt == '0 && s_r.por_done)
		else $error("power-up clear of the prescaler missing");
	AST_DIS_NO_RST: assert property (
		s_r.cfg[`WDT_CFG_DIS] |=> !wdog_reset_req)
		else $error("reset requested while disabled");
	AST_PIN_LEN: assert property (
		$fell(rst_pin_oe) |-> $past(pin_ticks) == 8'(RST_PULSE - 1)
		&& $past(internal_osc_clock_tick))
		else $error("reset pin low for the wrong tick count");
	AST_CAUSE_SET: assert property (
		wdog_reset_req |-> rst_pin_oe && s_r.cause[`WDT_CAUSE_WDOG])
		else $error("overflow without pin drive or cause flag");
	AST_MASKED_QUIET: assert property (
		s_r.mask == '0 |-> !irq)
		else $error("interrupt raised with everything masked");
	AST_STOP_GATES: assert property (
		s_r.pwr == WDT_STOP |-> pre_cnt == '0 ##1 !wdog_reset_req)
		else $error("prescaler ran during stop");
	AST_ILLEGAL_STOP: assert property (
		stop_exec && s_r.pwr == WDT_RUN && s_r.cfg[`WDT_CFG_STOPDIS]
		|=> illegal_op_reset && !stop_mode)
		else $error("disabled stop did not give an illegal reset");
	AST_INT_RESET: assert property (
		internal_reset |=> s_r.wd_cnt == '0 && pre_cnt == '0)
		else $error("internal reset left a count behind");
	AST_MON_DIS: assert property (
		monitor_mode && test_high_voltage_irq |=> !wdog_reset_req)
		else $error("reset requested in monitor mode");
	AST_BRK_DIS: assert property (
		break_active && test_high_voltage_rst |=> !wdog_reset_req)
		else $error("reset requested during break");
	AST_ONE_REQ: assert property (
		wdog_reset_req |=> !wdog_reset_req)
		else $error("reset request longer than one cycle");

	COV_SERVICE: cover property (service);
	COV_OVERFLOW: cover property (wdog_reset_req);
	COV_ILLEGAL: cover property (illegal_op_reset);
	COV_STOP: cover property (stop_mode ##1 !stop_mode);
endmodule : wdt_top
`default_nettype wire

/* File: pkg/wdt_consts.svh */
// Offsets, field positions and counts of the watchdog timeout unit.
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH
`define WDT_IDX_SERVICE 16'hFFFF
`define WDT_IDX_CONFIG 16'hFFF0
`define WDT_IDX_CAUSE 16'hFFF1
`define WDT_IDX_MASK 16'hFFF2
`define WDT_ADDR_W 18
`define WDT_IDX_W 16
`define WDT_PRE_W 12
`define WDT_CNT_W 6
`define WDT_LONG_STAGE 11
`define WDT_SHORT_STAGE 6
`define WDT_SVC_KEEP_LO 4
`define WDT_RST_PULSE 32
`define WDT_POR_CYCLES 4096
`define WDT_POR_W 13
`define WDT_CFG_W 3
`define WDT_CFG_TSEL 0
`define WDT_CFG_DIS 1
`define WDT_CFG_STOPDIS 2
`define WDT_CAUSE_W 2
`define WDT_CAUSE_WDOG 0
`define WDT_CAUSE_ILOP 1
`define WDT_CFG_RESET 3'h0
`define WDT_RESP_OKAY 2'h0
`define WDT_RESP_SLVERR 2'h2
`define WDT_VEC_LO 8'h00
`endif

/* File: pkg/wdt_pkg.sv */
// Types shared by the watchdog timeout unit.
`include "wdt_consts.svh"
package wdt_pkg;
	typedef enum logic [1:0] {
		WDT_RUN = 2'b01,
		WDT_STOP = 2'b10
	} wdt_pwr_t;

	typedef struct packed {
		wdt_pwr_t pwr;
		logic [`WDT_CNT_W-1:0] wd_cnt;
		logic [`WDT_POR_W-1:0] por_cnt;
		logic por_done;
		logic [`WDT_CFG_W-1:0] cfg;
		logic [`WDT_CAUSE_W-1:0] cause;
		logic [`WDT_CAUSE_W-1:0] mask;
		logic aw_have;
		logic [`WDT_IDX_W-1:0] aw_idx;
		logic w_have;
		logic [7:0] w_data;
		logic w_strb0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic wdog_req;
		logic ilop_req;
	} wdt_state_t;
endpackage : wdt_pkg

/* File: hdl/wdt_prescaler.sv */
// Prescaler counter with full clear and clear of the upper stages.
`timescale 1ns/1ns
`default_nettype none
module wdt_prescaler #(
	parameter int W = 12,
	parameter int KEEP_LO = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tick,
	input wire logic clr_all,
	input wire logic clr_hi,
	output logic [W-1:0] count
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} wdt_pre_t;

	localparam logic [W-1:0] LO_MASK = W'((1 << KEEP_LO) - 1);

	wdt_pre_t s_r;
	wdt_pre_t s_nxt;

	if (W < 2 || KEEP_LO < 0 || KEEP_LO >= W) begin : g_chk
		$error("wdt_prescaler: unusable width or kept stages");
	end

	always_comb begin
		s_nxt = s_r;
		if (clr_all) begin
			s_nxt.cnt = '0;
		end else if (clr_hi) begin
			s_nxt.cnt = s_r.cnt & LO_MASK;
		end else if (tick) begin
			s_nxt.cnt = s_r.cnt + W'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign count = s_r.cnt;
endmodule : wdt_prescaler
`default_nettype wire

/* File: hdl/wdt_pulse_stretch.sv */
// Holds an output for a fixed number of oscillator ticks after a start.
`timescale 1ns/1ns
`default_nettype none
module wdt_pulse_stretch #(
	parameter int LEN = 32
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic start,
	input wire logic tick,
	output logic active
);
	localparam int CW = $clog2(LEN + 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic act;
	} wdt_str_t;

	wdt_str_t s_r;
	wdt_str_t s_nxt;

	if (LEN < 1) begin : g_chk
		$error("wdt_pulse_stretch: length must be at least one");
	end

	always_comb begin
		s_nxt = s_r;
		if (start) begin
			s_nxt.act = 1'b1;
			s_nxt.cnt = '0;
		end else if (s_r.act && tick) begin
			if (s_r.cnt == CW'(LEN - 1)) begin
				s_nxt.act = 1'b0;
			end
			s_nxt.cnt = s_r.cnt + CW'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign active = s_r.act;
endmodule : wdt_pulse_stretch
`default_nettype wire

/* File: verification/wdt_cpu_model.sv */
// CPU side of the register bus: AXI4-Lite master used to service the unit.
`timescale 1ns/1ns
`default_nettype none
`include "wdt_consts.svh"
module wdt_cpu_model (
	input wire logic aclk,
	output logic [17:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	output logic bready,
	output logic [17:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready,
	output logic hung
);
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready, hung} = '0;
	end

	task automatic wr(input logic [15:0] idx, input logic [31:0] d);
		int i;
		logic ha;
		logic hw;
		ha = 1'b0;
		hw = 1'b0;
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 99 && !(ha && hw); i++) begin
			@(posedge aclk);
			if (awready) ha = 1'b1;
			if (wready) hw = 1'b1;
			awvalid <= !ha;
			wvalid <= !hw;
		end
		for (i = 0; i < 99 && !bvalid; i++) @(posedge aclk);
		bready <= 1'b0;
		if (i == 99) hung <= 1'b1;
	endtask : wr

	task automatic rd(input logic [15:0] idx, output logic [31:0] d,
		output logic [1:0] r);
		int i;
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 99; i++) begin
			@(posedge aclk);
			if (arready) break;
		end
		arvalid <= 1'b0;
		for (i = 0; i < 99 && !rvalid; i++) @(posedge aclk);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (i == 99) hung <= 1'b1;
	endtask : rd

	// Software services from its main loop, right after reset and around stop.
	task automatic svc();
		wr(`WDT_IDX_SERVICE, 32'h0000005A);
	endtask : svc
endmodule : wdt_cpu_model
`default_nettype wire

/* File: verification/watchdog_timeout_unit_test.sv */
// Self-checking bench of the watchdog timeout unit.
`timescale 1ns/1ns
`default_nettype none
`include "wdt_consts.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module watchdog_timeout_unit_test;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic tick = 1'b1;
	logic irst = 1'b0;
	logic vfetch = 1'b0;
	logic mon = 1'b0;
	logic thv_irq = 1'b0;
	logic thv_rst = 1'b0;
	logic brk = 1'b0;
	logic sexec = 1'b0;
	logic swake = 1'b0;
	logic [17:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, hung;
	logic stop_mode, req, ilop, pin, pin_oe, irq;
	int err_count = 0;
	int n_compared = 0;
	int n;
	int m;

	always #4 aclk = ~aclk;

	wdt_top #(.RST_PULSE(4), .POR_CYCLES(8), .VEC_LO(8'hA5)) DUT (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.internal_osc_clock_tick(tick), .internal_reset(irst),
		.vector_fetch(vfetch), .monitor_mode(mon),
		.test_high_voltage_irq(thv_irq), .test_high_voltage_rst(thv_rst),
		.break_active(brk), .stop_exec(sexec), .stop_wake(swake),
		.stop_mode(stop_mode), .wdog_reset_req(req),
		.illegal_op_reset(ilop), .rst_pin_out(pin), .rst_pin_oe(pin_oe),
		.irq(irq));

	wdt_cpu_model cpu (
		.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .hung(hung));

	task automatic close_out();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out

	always @(posedge hung) begin
		err_count++;
		close_out();
	end

	// Counts cycles up to mx or until a timeout request shows.
	task automatic wait_req(input int mx, output int k);
		k = 0;
		while (k < mx && req !== 1'b1) begin
			@(negedge aclk);
			k++;
		end
	endtask : wait_req

	task automatic t_regs();
		cpu.rd(`WDT_IDX_CONFIG, d, r);
		`CHK(d, 32'h0)
		cpu.rd(`WDT_IDX_CAUSE, d, r);
		`CHK(d, 32'h0)
		cpu.rd(`WDT_IDX_SERVICE, d, r);
		`CHK(d, 32'h000000A5)
		`CHK(r, `WDT_RESP_OKAY)
		cpu.rd(16'h0000, d, r);
		`CHK(r, `WDT_RESP_SLVERR)
		cpu.wr(`WDT_IDX_CONFIG, 32'h1);
		cpu.rd(`WDT_IDX_CONFIG, d, r);
		`CHK(d, 32'h1)
	endtask : t_regs

	// Short period lapses; a read in mid-period must not service.
	task automatic t_timeout();
		int k;
		cpu.svc();
		wait_req(4000, n);
		cpu.rd(`WDT_IDX_SERVICE, d, r);
		wait_req(5000, k);
		n = n + k;
		`CHK(n >= 8160 && n <= 8200, 1'b1)
		`CHK(pin, 1'b0)
		m = 0;
		while (pin_oe === 1'b1 && m < 99) begin
			m++;
			@(negedge aclk);
		end
		`CHK(m, 4)
		`CHK(irq, 1'b0)
		cpu.rd(`WDT_IDX_CAUSE, d, r);
		`CHK(d, 32'h1)
		cpu.wr(`WDT_IDX_MASK, 32'h1);
		@(negedge aclk);
		`CHK(irq, 1'b1)
		cpu.wr(`WDT_IDX_CAUSE, 32'h1);
		@(negedge aclk);
		`CHK(irq, 1'b0)
	endtask : t_timeout

	// Each case must keep the unit quiet well past the short period.
	task automatic t_quiet(input int kind);
		int k;
		cpu.svc();
		case (kind)
			2: cpu.wr(`WDT_IDX_CONFIG, 32'h3);
			3: {mon, thv_irq} <= 2'b11;
			4: {mon, thv_rst} <= 2'b11;
			5: {brk, thv_rst} <= 2'b11;
			6: begin
				@(posedge aclk) sexec <= 1'b1;
				@(posedge aclk) sexec <= 1'b0;
				@(negedge aclk);
				`CHK(stop_mode, 1'b1)
			end
			default: ;
		endcase
		wait_req(4500, n);
		if (kind == 0) cpu.svc();
		if (kind == 1) begin
			@(posedge aclk) irst <= 1'b1;
			@(posedge aclk) irst <= 1'b0;
		end
		wait_req(5000, k);
		`CHK(n + k, 9500)
		{mon, thv_irq, thv_rst, brk} <= 4'h0;
		@(posedge aclk) swake <= (kind == 6);
		@(posedge aclk) swake <= 1'b0;
		cpu.wr(`WDT_IDX_CONFIG, 32'h1);
		@(negedge aclk);
		`CHK(stop_mode, 1'b0)
	endtask : t_quiet

	task automatic t_stop_off();
		cpu.wr(`WDT_IDX_CONFIG, 32'h5);
		@(posedge aclk) sexec <= 1'b1;
		@(posedge aclk) sexec <= 1'b0;
		@(negedge aclk);
		`CHK(ilop, 1'b1)
		`CHK(stop_mode, 1'b0)
		cpu.rd(`WDT_IDX_CAUSE, d, r);
		`CHK(d, 32'h2)
	endtask : t_stop_off

	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk) vfetch <= 1'b1;
		@(posedge aclk) vfetch <= 1'b0;
		t_regs();
		t_timeout();
		for (int i = 0; i < 7; i++) t_quiet(i);
		t_stop_off();
		close_out();
	end
endmodule : watchdog_timeout_unit_test
`default_nettype wire
